/* common/sdi_consts.vh */
`ifndef SDI_CONSTS_VH
`define SDI_CONSTS_VH
// wishbone register byte offsets
`define SDI_OFS_STATUS    6'h00
`define SDI_OFS_MODE0     6'h04
`define SDI_OFS_MODE1     6'h08
`define SDI_OFS_MODE2     6'h0C
`define SDI_OFS_MODE3     6'h10
`define SDI_OFS_LASTCMD   6'h14
`define SDI_OFS_CONTROL   6'h18
// control register field positions
`define SDI_CTL_CLR       0
// status register field positions
`define SDI_ST_RESET      0
`define SDI_ST_CKE        1
`define SDI_ST_TERMHIZ    2
`define SDI_ST_MODESEEN   6:3
`define SDI_ST_DLLRST     7
`define SDI_ST_DLLEN      8
`define SDI_ST_ACTIVE     16:9
`define SDI_ST_ERR        17
`define SDI_ST_TERMLVL    18
// reset values
`define SDI_MODE_RST      16'h0000
`define SDI_CMD_RST       8'h00
// command encodings {csN, rasN, casN, weN}
`define SDI_CMD_MRS       4'h0
`define SDI_CMD_ACT       4'h3
`define SDI_CMD_RD        4'h5
`define SDI_CMD_WR        4'h4
`define SDI_CMD_PRE       4'h2
`define SDI_CMD_NOP       4'h7
// address bit positions
`define SDI_A_AP          10
`define SDI_A_BC          12
`define SDI_A_DLLDIS      0
`define SDI_A_DLLRST      8
// burst lengths in words at the pins
`define SDI_BURST_FULL    4'h8
`define SDI_BURST_CHOP    4'h4
`endif

/* hw/sdi_sync.v */
`timescale 1ns/1ps
// two-stage synchroniser; first stage is read by the second only
module sdi_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clk,
	input  wire             rstSyncB,
	// data
	input  wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	// capture the pin then settle it for one more edge
	always @(posedge clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
		begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
		end
		else
		begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncOut = stage2_reg;
endmodule

/* hw/sdi_bank_rows.v */
`timescale 1ns/1ps
// per-bank open-row tracker: one entry per bank, built by a generate loop
module sdi_bank_rows #(
	parameter BANKS    = 8,
	parameter ROW_BITS = 14,
	parameter BA_BITS  = 3
) (
	// clock and reset
	input  wire               clk,
	input  wire               rstSyncB,
	input  wire               clearAll,
	// commands
	input  wire               actStrobe,
	input  wire               preStrobe,
	input  wire               preAll,
	input  wire [BA_BITS-1:0] bankSel,
	input  wire [ROW_BITS-1:0] rowIn,
	// state
	output wire [BANKS-1:0]   bankOpen,
	output wire [ROW_BITS-1:0] selRow
);
	reg [ROW_BITS-1:0] rowMem [0:BANKS-1];
	reg [BANKS-1:0]    open_reg;

	genvar b;
	generate
		for (b = 0; b < BANKS; b = b + 1)
		begin : gBank
			// open on activate, close on precharge of this bank or all banks
			always @(posedge clk or negedge rstSyncB)
			begin
				if (!rstSyncB)
				begin
					open_reg[b] <= 1'b0;
					rowMem[b]   <= {ROW_BITS{1'b0}};
				end
				else if (clearAll)
					open_reg[b] <= 1'b0;
				else if (actStrobe && bankSel == b)
				begin
					open_reg[b] <= 1'b1;
					rowMem[b]   <= rowIn;
				end
				else if (preStrobe && (preAll || bankSel == b))
					open_reg[b] <= 1'b0;
			end
		end
	endgenerate

	assign bankOpen = open_reg;
	assign selRow   = rowMem[bankSel];
endmodule

/* hw/sdi_sdram_init.v */
`timescale 1ns/1ps
`include "sdi_consts.vh"
// Overview of operation
// (R1) eight banks, 8n prefetch: each access moves eight or four words, two per clock
// (R2) activate latches bank from three bank lines and row from fourteen address lines
// (R3) read/write take column from address, A10 auto precharge, A12 chop select
// (R4) controller holds reset at least 200 us after power stable; the model holds it RST_HOLD link periods, 800 ns, in enter_reset
// (R5) controller drops clock enable at least 10 ns before releasing reset
// (R6) 500 us wait after reset release before clock enable; device initialises internally; the model waits INIT_WAIT link periods, 1600 ns, then CLK_PRE more
// (R7) controller runs clock and registers NOP before raising clock enable
// (R8) controller keeps clock enable high until initialisation finishes
// (R9) termination stays high impedance during reset and until clock enable seen high
// (R10) controller holds termination control static, low if nominal termination used
// (R11) controller waits reset exit time before first mode-set
// (R12) controller loads mode registers in order 2, 3, 1, 0
// (R13) mode 1 write enables DLL via A0 low; mode 0 requests DLL reset via A8
// (R14) controller issues long calibration and waits lock and calibration times
// (R15) warm reset: at least 100 ns, then repeat steps from the 500 us wait
// (R16) mode contents undefined after reset; mode writes keep the array intact
// (R17) controller drives every field of a mode register on each mode-set
// (R18) controller spaces two mode-sets by the mode-set cycle time
// (R19) controller waits the mode-update delay before non mode-set commands
// (R20) mode rewrites only when idle with all banks precharged
// (R21) termination control low around mode-set when nominal termination enabled
// (R22) reset pin is asynchronous active low and destroys stored data
// (R23) burst-chop input high selects full burst, low selects chopped burst
// (R24) controller holds every init timing as cycle-count parameters; the 20 ns clock-enable lead before reset is a literal delay
module sdi_sdram_init #(
	parameter BANKS    = 8,
	parameter ROW_BITS = 14,
	parameter BA_BITS  = 3
) (
	// system clock and reset
	input  wire        clk,
	input  wire        rst_b,
	// memory pins from the controller
	input  wire        memClk,
	input  wire        memResetB,
	input  wire        cke,
	input  wire        csB,
	input  wire        rasB,
	input  wire        casB,
	input  wire        weB,
	input  wire [2:0]  bankAddr,
	input  wire [13:0] addr,
	input  wire        termination_control_in,
	// termination state
	output reg         termHiZ,
	// burst indication
	output reg         burstStart,
	output reg  [3:0]  burstWords,
	output reg         burstWrite,
	output reg  [9:0]  burstCol,
	output reg         autoPrecharge,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [5:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o
);
	reg         rstMeta_reg;
	reg         rstSync_reg;
	wire        rstSyncB = rstSync_reg;

	// release reset through two flops
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end
		else
		begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end

	// all pins come from the controller's domain
	wire [24:0] pinSync;
	sdi_sync #(.WIDTH(25)) uSync (
		.clk      (clk),
		.rstSyncB (rstSyncB),
		.asyncIn  ({memClk, memResetB, cke, csB, rasB, casB, weB, bankAddr, addr, termination_control_in}),
		.syncOut  (pinSync)
	);
	wire        sClk   = pinSync[24];
	wire        sRstB  = pinSync[23];
	wire        sCke   = pinSync[22];
	wire [3:0]  sCmd   = pinSync[21:18];
	wire [2:0]  sBa    = pinSync[17:15];
	wire [13:0] sAddr  = pinSync[14:1];
	wire        sTerm  = pinSync[0];

	// find rising edges of the link clock; commands are sampled there
	reg         clkPrev_reg;
	wire        clkRise = sClk && !clkPrev_reg;

	localparam ST_RESET = 3'b001;
	localparam ST_WAIT  = 3'b010;
	localparam ST_RUN   = 3'b100;
	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;

	reg  [15:0] mode_reg [0:3];
	reg  [3:0]  modeSeen_reg;
	reg         dllRst_reg;
	reg         dllEn_reg;
	reg         ckeSeen_reg;
	reg         err_reg;
	reg  [7:0]  lastCmd_reg;
	reg         clearReq_reg;

	// device state machine; no clock edges are needed while in reset
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET: if (sRstB) state_next = ST_WAIT; // (R6)
			ST_WAIT:  if (clkRise && sCke) state_next = ST_RUN;
			ST_RUN:   state_next = ST_RUN;
			default:  state_next = ST_RESET;
		endcase
		if (!sRstB)
			state_next = ST_RESET; // (R22)
	end

	wire        csB_sync_n = sCmd[3];
	wire        cmdValid = clkRise && ckeSeen_reg && sRstB && !csB_sync_n;
	wire        isMrs  = cmdValid && sCmd == `SDI_CMD_MRS;
	wire        isAct  = cmdValid && sCmd == `SDI_CMD_ACT;
	wire        isRd   = cmdValid && sCmd == `SDI_CMD_RD;
	wire        isWr   = cmdValid && sCmd == `SDI_CMD_WR;
	wire        isPre  = cmdValid && sCmd == `SDI_CMD_PRE;
	wire [1:0]  mrSel  = sBa[1:0];
	// on-the-fly chop only when mode 0 length field selects it
	wire        otfEn  = mode_reg[0][1:0] == 2'h1;
	wire        fixChop = mode_reg[0][1:0] == 2'h2;

	wire [BANKS-1:0]    bankOpen;
	wire [ROW_BITS-1:0] selRow;
	wire                clearBanks = state_reg == ST_RESET;
	sdi_bank_rows #(.BANKS(BANKS), .ROW_BITS(ROW_BITS), .BA_BITS(BA_BITS)) uRows (
		.clk       (clk),
		.rstSyncB  (rstSyncB),
		.clearAll  (clearBanks),
		.actStrobe (isAct), // (R2)
		.preStrobe (isPre || ((isRd || isWr) && sAddr[`SDI_A_AP])),
		.preAll    (isPre && sAddr[`SDI_A_AP]),
		.bankSel   (sBa),
		.rowIn     (sAddr),
		.bankOpen  (bankOpen),
		.selRow    ()
	);

	wire        bankIsOpen = bankOpen[sBa];
	wire        anyOpen    = |bankOpen;
	integer     i;

	// main sequential state
	always @(posedge clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
		begin
			clkPrev_reg   <= 1'b0;
			state_reg     <= ST_RESET;
			modeSeen_reg  <= 4'h0;
			dllRst_reg    <= 1'b0;
			dllEn_reg     <= 1'b0;
			ckeSeen_reg   <= 1'b0;
			err_reg       <= 1'b0;
			lastCmd_reg   <= `SDI_CMD_RST;
			termHiZ       <= 1'b1;
			burstStart    <= 1'b0;
			burstWords    <= 4'h0;
			burstWrite    <= 1'b0;
			burstCol      <= 10'h000;
			autoPrecharge <= 1'b0;
			for (i = 0; i < 4; i = i + 1)
				mode_reg[i] <= `SDI_MODE_RST;
		end
		else
		begin
			clkPrev_reg <= sClk;
			state_reg   <= state_next;
			burstStart  <= 1'b0;
			// clear first so that an error in the same cycle still sets the flag
			if (clearReq_reg)
				err_reg <= 1'b0;
			if (state_next == ST_RESET)
			begin
				// mode contents become undefined; report them as unwritten
				modeSeen_reg <= 4'h0; // (R16)
				dllRst_reg   <= 1'b0;
				dllEn_reg    <= 1'b0;
				ckeSeen_reg  <= 1'b0;
				termHiZ      <= 1'b1; // (R9)
			end
			else if (state_reg == ST_WAIT && state_next == ST_RUN)
			begin
				ckeSeen_reg <= 1'b1;
				termHiZ     <= 1'b0; // (R9)
			end
			if (isMrs)
			begin
				// mode write touches only the mode file, never the array
				mode_reg[mrSel]     <= {2'h0, sAddr}; // (R16)
				modeSeen_reg[mrSel] <= 1'b1;
				if (mrSel == 2'h1)
					dllEn_reg <= !sAddr[`SDI_A_DLLDIS]; // (R13)
				if (mrSel == 2'h0)
					dllRst_reg <= sAddr[`SDI_A_DLLRST]; // (R13)
				// mode-set with a bank open breaks the idle condition
				if (anyOpen || sBa[2])
					err_reg <= 1'b1;
			end
			if (isRd || isWr)
			begin
				burstStart    <= 1'b1;
				burstWrite    <= isWr;
				burstCol      <= sAddr[9:0]; // (R3)
				autoPrecharge <= sAddr[`SDI_A_AP]; // (R3)
				// in on-the-fly mode chop four when low, full eight when high; field 2 always four, 0 and 3 always eight (R23)
				if (fixChop || (otfEn && !sAddr[`SDI_A_BC]))
					burstWords <= `SDI_BURST_CHOP; // (R1)
				else
					burstWords <= `SDI_BURST_FULL; // (R1)
				if (!bankIsOpen)
					err_reg <= 1'b1; // (R2)
			end
			if (cmdValid)
				lastCmd_reg <= {1'b0, sBa, sCmd};
		end
	end

	// wishbone: one wait state then ack; ack drops after one cycle
	wire        wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// bit 18 mirrors the termination control level so software can see it held static
	wire [31:0] statusWord = {13'h0000, sTerm, err_reg, bankOpen, dllEn_reg, dllRst_reg, modeSeen_reg,
	                          termHiZ, ckeSeen_reg, state_reg == ST_RESET};

	always @(posedge clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
		begin
			wb_ack_o     <= 1'b0;
			wb_dat_o     <= 32'h00000000;
			clearReq_reg <= 1'b0;
		end
		else
		begin
			wb_ack_o     <= wbReq;
			clearReq_reg <= 1'b0;
			// a write lands at the edge where the master samples ack high
			if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `SDI_OFS_CONTROL && wb_sel_i[0])
				clearReq_reg <= wb_dat_i[`SDI_CTL_CLR];
			if (wbReq && !wb_we_i)
			begin
				case (wb_adr_i)
					`SDI_OFS_STATUS:  wb_dat_o <= statusWord;
					`SDI_OFS_MODE0:   wb_dat_o <= {16'h0000, mode_reg[0]};
					`SDI_OFS_MODE1:   wb_dat_o <= {16'h0000, mode_reg[1]};
					`SDI_OFS_MODE2:   wb_dat_o <= {16'h0000, mode_reg[2]};
					`SDI_OFS_MODE3:   wb_dat_o <= {16'h0000, mode_reg[3]};
					`SDI_OFS_LASTCMD: wb_dat_o <= {24'h000000, lastCmd_reg};
					default:          wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

/* tb/sdi_sdram_init_checker.sv */
`timescale 1ns/1ps
// watches the top ports; everything runs on the system clock
module sdi_sdram_init_checker (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       memResetB,
	input wire logic       cke,
	input wire logic       termHiZ,
	input wire logic       burstStart,
	input wire logic [3:0] burstWords,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
	a_burst_pulse: assert property (burstStart |=> !burstStart) else $error("burst pulse long");
	a_burst_size: assert property (burstStart |-> burstWords == 4'h8 || burstWords == 4'h4) else $error("size");
	a_burst_live: assert property (burstStart |-> !termHiZ && memResetB) else $error("burst in reset");
	// the pin passes two sync flops, so five low samples must show
	a_hiz_reset: assert property (!memResetB [*5] |=> termHiZ) else $error("termination on");
	a_hiz_exit: assert property ($fell(termHiZ) |-> cke && memResetB) else $error("early exit");
	a_reset_quiet: assert property ($rose(rst_b) |-> termHiZ && !burstStart && !wb_ack_o) else $error("rst out");
	c_chop: cover property (burstStart && burstWords == 4'h4);
	c_full: cover property (burstStart && burstWords == 4'h8);
	c_hiz_exit: cover property ($fell(termHiZ));
endmodule
bind sdi_sdram_init sdi_sdram_init_checker chk_u (.clk, .rst_b, .memResetB, .cke, .termHiZ, .burstStart,
	.burstWords, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

/* tb/sdi_ctrl_model.sv */
`timescale 1ns/1ps
`include "sdi_consts.vh"
// stand-in memory controller; every wait but the 20 ns clock-enable lead counted in link clock periods
module sdi_ctrl_model #(
	parameter int RST_HOLD = 2, INIT_WAIT = 4, CLK_PRE = 5, XPR = 5, MRD = 4, MOD = 12, ZQ_WAIT = 8
) (
	output logic        memClk,
	output logic        memResetB,
	output logic        cke,
	output logic        csB,
	output logic        rasB,
	output logic        casB,
	output logic        weB,
	output logic [2:0]  bankAddr,
	output logic [13:0] addr,
	output logic        termination_control_in
);
	logic clkRun = 0;
	// clock rests low while stopped; odd offset keeps it unrelated to clk
	initial
	begin
		memClk = 0;
		#7;
		forever #200 memClk = clkRun & ~memClk;
	end
	// termination held low throughout since nominal termination may be on
	initial
	begin
		memResetB = 0;
		cke = 0;
		{csB, rasB, casB, weB} = `SDI_CMD_NOP;
		bankAddr = 0;
		addr = 0;
		termination_control_in = 0;
	end
	// one command held for a whole link period, then idle with a scrambled bus
	task send(input [3:0] c, input [2:0] b, input [13:0] a, input int gap);
		@(negedge memClk);
		{csB, rasB, casB, weB} = c;
		bankAddr = b;
		addr = a;
		@(negedge memClk);
		{csB, rasB, casB, weB} = `SDI_CMD_NOP;
		bankAddr = ~b;
		addr = ~a;
		repeat (gap) @(negedge memClk);
	endtask
	// clock enable always drops before reset
	task enter_reset;
		cke = 0;
		#20;
		memResetB = 0;
		clkRun = 0;
		#(RST_HOLD * 400);
	endtask
	task init_seq(input [13:0] m0, m1, m2, m3);
		memResetB = 1;
		#(INIT_WAIT * 400);
		clkRun = 1;
		repeat (CLK_PRE) @(negedge memClk);
		cke = 1;
		repeat (XPR) @(negedge memClk);
		send(`SDI_CMD_MRS, 3'h2, m2, MRD);
		send(`SDI_CMD_MRS, 3'h3, m3, MRD);
		send(`SDI_CMD_MRS, 3'h1, m1 & 14'h3FFE, MRD);
		send(`SDI_CMD_MRS, 3'h0, m0 | 14'h0100, MOD);
		send(4'h6, 3'h0, 14'h0400, ZQ_WAIT);
	endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
`include "sdi_consts.vh"
module tb_top;
	logic        clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0;
	logic [5:0]  adr = 0;
	logic [31:0] dat = 0, rd;
	logic [15:0] bLast = 0;
	int          bCnt = 0, num_errors = 0, compares = 0, cycles = 0;
	wire         memClk, memResetB, cke, csB, rasB, casB, weB, termCtl, termHiZ, burstStart, burstWrite, ap, ack;
	wire [2:0]   ba;
	wire [13:0]  a;
	wire [3:0]   burstWords;
	wire [9:0]   burstCol;
	wire [31:0]  q;
	initial forever #25 clk = ~clk;
	sdi_ctrl_model m (.memClk, .memResetB, .cke, .csB, .rasB, .casB, .weB, .bankAddr(ba), .addr(a),
		.termination_control_in(termCtl));
	sdi_sdram_init dut_u (.clk, .rst_b, .memClk, .memResetB, .cke, .csB, .rasB, .casB, .weB, .bankAddr(ba),
		.addr(a), .termination_control_in(termCtl), .termHiZ, .burstStart, .burstWords, .burstWrite, .burstCol,
		.autoPrecharge(ap), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack));
	task chk(input [31:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// classic cycle: request held until ack is sampled, data taken there
	task wb(input logic w, input [5:0] ad, input [31:0] d);
		int n;
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, ad, d};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = q;
		{cyc, stb} <= 2'b00;
		if (n >= 50)
			chk(0, 1);
	endtask
	task rdchk(input [5:0] ad, input [31:0] mask, exp);
		wb(0, ad, 0);
		chk(rd & mask, exp);
	endtask
	task print_verdict;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			print_verdict;
		end
	end
	always @(posedge clk)
		if (burstStart === 1'b1)
		begin
			bLast <= {ap, burstWrite, burstWords, burstCol};
			bCnt <= bCnt + 1;
		end
	initial
	begin
		repeat (5) @(posedge clk);
		rst_b <= 1;
		m.enter_reset;
		chk(termHiZ, 1);
		rdchk(`SDI_OFS_STATUS, 32'h3FFFE, 32'h4);
		rdchk(6'h1C, '1, 0);
		wb(1, `SDI_OFS_MODE0, 32'h1234);
		rdchk(`SDI_OFS_MODE0, '1, 0);
		m.init_seq(14'h0101, 14'h0044, 14'h0008, 14'h0000);
		rdchk(`SDI_OFS_STATUS, 32'h7FFFE, 32'h1FA);
		rdchk(`SDI_OFS_MODE2, '1, 32'h8);
		rdchk(`SDI_OFS_MODE1, '1, 32'h44);
		rdchk(`SDI_OFS_MODE0, '1, 32'h101);
		m.send(`SDI_CMD_ACT, 3'h5, 14'h2A5C, 2);
		rdchk(`SDI_OFS_STATUS, 32'h1FE00, 32'h4000);
		// idle cycles count as commands; the model leaves the bank lines inverted after the activate
		rdchk(`SDI_OFS_LASTCMD, '1, {24'h000000, 1'b0, ~3'h5, `SDI_CMD_NOP});
		m.send(`SDI_CMD_WR, 3'h5, 14'h11F3, 2);
		chk(bLast, {2'b01, `SDI_BURST_FULL, 10'h1F3});
		m.send(`SDI_CMD_RD, 3'h5, 14'h07C4, 2);
		chk(bLast, {2'b10, `SDI_BURST_CHOP, 10'h3C4});
		chk(bCnt, 2);
		m.send(`SDI_CMD_RD, 3'h2, 14'h0000, 2);
		rdchk(`SDI_OFS_STATUS, 32'h20000, 32'h20000);
		wb(1, `SDI_OFS_CONTROL, 32'h1);
		rdchk(`SDI_OFS_STATUS, 32'h20000, 0);
		// burst length modes 1, 2 and 0, read with the chop bit low
		for (int i = 0; i < 3; i++)
		begin
			m.send(`SDI_CMD_PRE, 3'h0, 14'h0400, 2);
			m.send(`SDI_CMD_MRS, 3'h0, (i == 2) ? 14'h0 : 14'(i + 1), m.MOD);
			rdchk(`SDI_OFS_MODE0, '1, (i == 2) ? 0 : i + 1);
			m.send(`SDI_CMD_ACT, 3'h1, 14'h0011, 2);
			m.send(`SDI_CMD_RD, 3'h1, 14'h0005, 2);
			chk(bLast, {2'b00, (i == 2) ? `SDI_BURST_FULL : `SDI_BURST_CHOP, 10'h005});
		end
		m.enter_reset;
		rdchk(`SDI_OFS_STATUS, 32'h7C, 32'h4);
		m.init_seq(14'h0101, 14'h0044, 14'h0008, 14'h0000);
		rdchk(`SDI_OFS_STATUS, 32'h3FFFE, 32'h1FA);
		print_verdict;
	end
endmodule
